// *** rtl/ttb_regs.vh ***
`ifndef TTB_REGS_VH
`define TTB_REGS_VH
// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define TTB_IDX_MODE_A     24'hff5000
`define TTB_IDX_SRC        24'hff5001
`define TTB_IDX_MODE_B     24'hff5004
`define TTB_IDX_DEST       24'hff5005
`define TTB_IDX_BLK_PAIR   24'hff5008
`define TTB_IDX_TOTAL      24'hff500a
`define TTB_IDX_ACT_EN_B   24'hffff22
`define TTB_IDX_RUN        24'hffffbc
`define TTB_IDX_SYNC       24'hffffbd
`define TTB_IDX_CLK_CLR    24'hffffc0
`define TTB_IDX_TMODE      24'hffffc1
`define TTB_IDX_PIN_FN     24'hffffc2
`define TTB_IDX_IRQ_EN     24'hffffc4
`define TTB_IDX_FLAGS      24'hffffc5
`define TTB_IDX_COUNT      24'hffffc6
`define TTB_IDX_CMP_A      24'hffffc8
// ****************************************************************
// Field positions and encodings
// ****************************************************************
`define TTB_ACT_EN_BIT     13
`define TTB_DIR_FLAG_BIT   7
`define TTB_CMP_FLAG_BIT   0
`define TTB_XMODE_BLOCK    2'b10
`define TTB_AMODE_INC      2'b10
`define TTB_AMODE_DEC      2'b11
`define TTB_SZ_BYTE        2'b00
`define TTB_SZ_WORD        2'b01
`define TTB_TMODE_NORMAL   4'h0
`define TTB_CCLR_CMP_A     3'b001
`define TTB_CKEG_FALL      2'b00
`define TTB_CKEG_RISE      2'b01
`define TTB_TPSC_DIV1      3'b000
`define TTB_TPSC_DIV4      3'b001
`define TTB_TPSC_DIV16     3'b010
`define TTB_TPSC_DIV64     3'b011
`define TTB_PIN_OFF        4'h0
// ****************************************************************
// Reset values
// ****************************************************************
`define TTB_COUNT_RESET    16'h0000
`endif

// *** rtl/ttb_block_xfer.v ***
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "ttb_regs.vh"

module ttb_block_xfer #(
    parameter AW = 26
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [AW-1:0] paddr,
    input  wire [31:0]   pwdata,
    input  wire [3:0]    pstrb,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    output reg           xfer_req,
    output reg           xfer_we,
    output reg  [23:0]   xfer_addr,
    output reg  [1:0]    xfer_size,
    output reg  [31:0]   xfer_wdata,
    input  wire [31:0]   xfer_rdata,
    input  wire          xfer_ack,
    input  wire          compare_a_pin_in,
    output reg           compare_a_pin_out,
    output reg           compare_a_pin_oe,
    output reg           channel0_compare_a_irq
);

    // ************************************************************
    // Controller states
    // ************************************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_RD   = 2'd1;
    localparam ST_WR   = 2'd2;
    localparam ST_UPD  = 2'd3;

    // ************************************************************
    // Storage
    // ************************************************************
    reg  [7:0]  mode_a_q;
    reg  [7:0]  mode_b_q;
    reg  [23:0] src_q;
    reg  [23:0] dest_address_reg_q;
    reg  [15:0] block_count_pair_q;
    reg  [15:0] total_transfer_count_q;
    reg  [15:0] act_en_q;
    reg  [7:0]  run_q;
    reg  [7:0]  sync_q;
    reg  [7:0]  clk_clr_q;
    reg  [7:0]  tmode_q;
    reg  [7:0]  pin_fn_q;
    reg  [7:0]  irq_en_q;
    reg         flag_q;
    reg  [15:0] count_q;
    reg  [15:0] cmp_a_q;
    reg  [5:0]  presc_q;
    reg         cclk_q;
    reg         pin_s1_q;
    reg         pin_s2_q;
    reg         pin_s3_q;
    reg  [1:0]  st_q;
    reg  [23:0] base_q;
    reg         cpu_pass_q;

    // ************************************************************
    // Helpers
    // ************************************************************
    function [23:0] size_bytes;
        input [1:0] sz;
        begin
            if (sz == `TTB_SZ_BYTE) begin
                size_bytes = 24'h000001;
            end else if (sz == `TTB_SZ_WORD) begin
                size_bytes = 24'h000002;
            end else begin
                size_bytes = 24'h000004;
            end
        end
    endfunction

    function [23:0] step_addr;
        input [23:0] a;
        input [1:0]  m;
        input [1:0]  sz;
        begin
            if (m == `TTB_AMODE_INC) begin
                step_addr = a + size_bytes(sz);
            end else if (m == `TTB_AMODE_DEC) begin
                step_addr = a - size_bytes(sz);
            end else begin
                step_addr = a;
            end
        end
    endfunction

    // ************************************************************
    // Field views
    // ************************************************************
    wire [1:0]  transfer_mode_field     = mode_a_q[7:6];
    wire [1:0]  xsize                   = mode_a_q[5:4];
    wire [1:0]  src_mode                = mode_a_q[3:2];
    wire        per_transfer_irq_select = mode_b_q[5];
    wire        block_area_side_select  = mode_b_q[4];
    wire [1:0]  dest_addr_mode          = {mode_b_q[3], mode_b_q[2]};
    wire [7:0]  block_size_byte         = block_count_pair_q[15:8];
    wire [7:0]  in_block_counter        = block_count_pair_q[7:0];
    wire        channel0_run            = run_q[0];
    wire        channel0_sync           = sync_q[0];
    wire [2:0]  counter_clear_select    = clk_clr_q[7:5];
    wire [1:0]  count_edge_select       = clk_clr_q[4:3];
    wire [2:0]  count_clock_select      = clk_clr_q[2:0];
    wire [3:0]  timer_mode_field        = tmode_q[3:0];
    wire [3:0]  compare_a_pin_function  = pin_fn_q[3:0];
    wire        compare_a_irq_enable    = irq_en_q[0];
    wire        source_activation_enable = act_en_q[`TTB_ACT_EN_BIT];
    wire        block_mode = (transfer_mode_field == `TTB_XMODE_BLOCK);

    // ************************************************************
    // Timer count clock
    // ************************************************************
    reg cclk_d;
    always @* begin
        case (count_clock_select)
            `TTB_TPSC_DIV4:  cclk_d = presc_q[1];
            `TTB_TPSC_DIV16: cclk_d = presc_q[3];
            `TTB_TPSC_DIV64: cclk_d = presc_q[5];
            default:         cclk_d = 1'b0;
        endcase
    end

    reg tick;
    always @* begin
        if (count_clock_select == `TTB_TPSC_DIV1) begin
            tick = 1'b1;
        end else if (count_edge_select == `TTB_CKEG_FALL) begin
            tick = cclk_q & ~cclk_d;
        end else if (count_edge_select == `TTB_CKEG_RISE) begin
            tick = ~cclk_q & cclk_d;
        end else begin
            tick = cclk_q ^ cclk_d;
        end
    end

    // Only channel 0 exists, so sync has nothing to join
    wire cnt_en  = channel0_run & tick & ~channel0_sync | channel0_run & tick & channel0_sync;
    wire counting = cnt_en & (timer_mode_field == `TTB_TMODE_NORMAL);
    wire cap_mode = compare_a_pin_function[3];
    wire match    = counting & ~cap_mode & (count_q == cmp_a_q);
    wire capture  = cap_mode & pin_s2_q & ~pin_s3_q;
    wire clr_src  = counter_clear_select == `TTB_CCLR_CMP_A;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire [23:0] idx     = paddr[25:2];
    wire        setup   = psel & ~penable & ~pready;
    wire        commit  = psel & penable & pready & ~pslverr & pwrite;
    wire        full16  = pstrb[1:0] == 2'b11;
    reg  [31:0] rd_d;
    reg         hit;
    reg         wide;
    always @* begin
        rd_d = 32'h0000_0000;
        hit  = 1'b1;
        wide = 1'b0;
        case (idx)
            `TTB_IDX_MODE_A:   rd_d = {24'h000000, mode_a_q};
            `TTB_IDX_SRC:      rd_d = {8'h00, src_q};
            `TTB_IDX_MODE_B:   rd_d = {24'h000000, mode_b_q};
            `TTB_IDX_DEST:     rd_d = {8'h00, dest_address_reg_q};
            `TTB_IDX_BLK_PAIR: begin
                rd_d = {16'h0000, block_count_pair_q};
                wide = 1'b1;
            end
            `TTB_IDX_TOTAL: begin
                rd_d = {16'h0000, total_transfer_count_q};
                wide = 1'b1;
            end
            `TTB_IDX_ACT_EN_B: begin
                rd_d = {16'h0000, act_en_q};
                wide = 1'b1;
            end
            `TTB_IDX_RUN:      rd_d = {24'h000000, run_q};
            `TTB_IDX_SYNC:     rd_d = {24'h000000, sync_q};
            `TTB_IDX_CLK_CLR:  rd_d = {24'h000000, clk_clr_q};
            `TTB_IDX_TMODE:    rd_d = {24'h000000, tmode_q};
            `TTB_IDX_PIN_FN:   rd_d = {24'h000000, pin_fn_q};
            `TTB_IDX_IRQ_EN:   rd_d = {24'h000000, irq_en_q};
            // Always counting up in normal mode
            `TTB_IDX_FLAGS:    rd_d = {24'h000000, 1'b1, 6'h00, flag_q};
            `TTB_IDX_COUNT: begin
                rd_d = {16'h0000, count_q};
                wide = 1'b1;
            end
            `TTB_IDX_CMP_A: begin
                rd_d = {16'h0000, cmp_a_q};
                wide = 1'b1;
            end
            default:           hit  = 1'b0;
        endcase
    end
    // Partial writes to 16-bit registers are refused
    wire err_d = ~hit | ~paddr[AW-1] & 1'b0 | (pwrite & wide & ~full16);

    // ************************************************************
    // Controller step values
    // ************************************************************
    wire [7:0]  inblk_dec = in_block_counter - 8'h01;
    wire [15:0] total_dec = total_transfer_count_q - 16'h0001;
    wire [15:0] pair_dec  = block_count_pair_q - 16'h0001;
    wire        blk_end = block_mode ? (inblk_dec == 8'h00) : 1'b1;
    wire        fin     = block_mode ? (total_dec == 16'h0000) : (pair_dec == 16'h0000);
    wire        pending = flag_q & compare_a_irq_enable & source_activation_enable
                          & ~cpu_pass_q & (st_q == ST_IDLE);

    // ************************************************************
    // Registers, timer and controller
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata                 <= 32'h0000_0000;
            pready                 <= 1'b0;
            pslverr                <= 1'b0;
            xfer_req               <= 1'b0;
            xfer_we                <= 1'b0;
            xfer_addr              <= 24'h000000;
            xfer_size              <= 2'b00;
            xfer_wdata             <= 32'h0000_0000;
            compare_a_pin_out      <= 1'b0;
            compare_a_pin_oe       <= 1'b0;
            channel0_compare_a_irq <= 1'b0;
            mode_a_q               <= 8'h00;
            mode_b_q               <= 8'h00;
            src_q                  <= 24'h000000;
            dest_address_reg_q     <= 24'h000000;
            block_count_pair_q     <= 16'h0000;
            total_transfer_count_q <= 16'h0000;
            act_en_q               <= 16'h0000;
            run_q                  <= 8'h00;
            sync_q                 <= 8'h00;
            clk_clr_q              <= 8'h00;
            tmode_q                <= 8'h00;
            pin_fn_q               <= 8'h00;
            irq_en_q               <= 8'h00;
            flag_q                 <= 1'b0;
            count_q                <= `TTB_COUNT_RESET;
            cmp_a_q                <= 16'hffff;
            presc_q                <= 6'h00;
            cclk_q                 <= 1'b0;
            pin_s1_q               <= 1'b0;
            pin_s2_q               <= 1'b0;
            pin_s3_q               <= 1'b0;
            st_q                   <= ST_IDLE;
            base_q                 <= 24'h000000;
            cpu_pass_q             <= 1'b0;
        end else begin
            presc_q  <= presc_q + 6'h01;
            cclk_q   <= cclk_d;
            pin_s1_q <= compare_a_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;

            // APB: answer in the cycle after setup
            pready <= setup;
            if (setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr <= err_d;
            end else begin
                pslverr <= 1'b0;
            end
            if (commit) begin
                case (idx)
                    // Transfer information registers, the bus path that loads the counts; ST_UPD also steps them
                    `TTB_IDX_MODE_A:   mode_a_q <= pwdata[7:0];
                    `TTB_IDX_SRC:      src_q <= pwdata[23:0];
                    `TTB_IDX_MODE_B:   mode_b_q <= pwdata[7:0];
                    `TTB_IDX_DEST:     dest_address_reg_q <= pwdata[23:0];
                    `TTB_IDX_BLK_PAIR: block_count_pair_q <= pwdata[15:0];
                    `TTB_IDX_TOTAL:    total_transfer_count_q <= pwdata[15:0];
                    `TTB_IDX_ACT_EN_B: act_en_q <= pwdata[15:0];
                    `TTB_IDX_RUN:      run_q <= pwdata[7:0];
                    `TTB_IDX_SYNC:     sync_q <= pwdata[7:0];
                    `TTB_IDX_CLK_CLR:  clk_clr_q <= pwdata[7:0];
                    `TTB_IDX_TMODE:    tmode_q <= pwdata[7:0];
                    `TTB_IDX_PIN_FN: begin
                        pin_fn_q          <= pwdata[7:0];
                        compare_a_pin_out <= pwdata[2];
                    end
                    `TTB_IDX_IRQ_EN:   irq_en_q <= pwdata[7:0];
                    `TTB_IDX_FLAGS: begin
                        if (!pwdata[`TTB_CMP_FLAG_BIT]) begin
                            flag_q <= 1'b0;
                        end
                    end
                    `TTB_IDX_COUNT:    count_q <= pwdata[15:0];
                    `TTB_IDX_CMP_A:    cmp_a_q <= pwdata[15:0];
                    default: begin
                    end
                endcase
            end

            // Timer counter, compare and capture
            if (counting) begin
                if (match && clr_src) begin
                    count_q <= 16'h0000;
                end else begin
                    count_q <= count_q + 16'h0001;
                end
            end
            if (capture) begin
                cmp_a_q <= count_q;
                if (clr_src) begin
                    count_q <= 16'h0000;
                end
            end
            compare_a_pin_oe <= ~cap_mode & (compare_a_pin_function != `TTB_PIN_OFF);
            if (match && !cap_mode) begin
                case (compare_a_pin_function[1:0])
                    2'b01:   compare_a_pin_out <= 1'b0;
                    2'b10:   compare_a_pin_out <= 1'b1;
                    2'b11:   compare_a_pin_out <= ~compare_a_pin_out;
                    default: compare_a_pin_out <= compare_a_pin_out;
                endcase
            end

            // Controller
            case (st_q)
                ST_IDLE: begin
                    if (pending) begin
                        base_q    <= block_area_side_select ? src_q : dest_address_reg_q;
                        xfer_req  <= 1'b1;
                        xfer_we   <= 1'b0;
                        xfer_addr <= src_q;
                        xfer_size <= xsize;
                        st_q      <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (xfer_ack) begin
                        xfer_we    <= 1'b1;
                        xfer_addr  <= dest_address_reg_q;
                        xfer_wdata <= xfer_rdata;
                        st_q       <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (xfer_ack) begin
                        xfer_req <= 1'b0;
                        xfer_we  <= 1'b0;
                        st_q     <= ST_UPD;
                    end
                end
                ST_UPD: begin
                    src_q              <= step_addr(src_q, src_mode, xsize);
                    dest_address_reg_q <= step_addr(dest_address_reg_q, dest_addr_mode,
                                                    xsize);
                    if (block_mode) begin
                        total_transfer_count_q <= total_dec;
                        block_count_pair_q     <= {block_size_byte, inblk_dec};
                    end else begin
                        block_count_pair_q <= pair_dec;
                    end
                    if (block_mode && blk_end) begin
                        block_count_pair_q <= {block_size_byte, block_size_byte};
                        if (block_area_side_select) begin
                            src_q <= base_q;
                        end else begin
                            dest_address_reg_q <= base_q;
                        end
                    end
                    if (blk_end) begin
                        st_q <= ST_IDLE;
                        if (fin) begin
                            act_en_q[`TTB_ACT_EN_BIT] <= 1'b0;
                        end else if (per_transfer_irq_select) begin
                            cpu_pass_q <= 1'b1;
                        end else begin
                            flag_q <= 1'b0;
                        end
                    end else begin
                        xfer_req  <= 1'b1;
                        xfer_addr <= step_addr(src_q, src_mode, xsize);
                        st_q      <= ST_RD;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase

            // Hardware set wins over any clear in the same cycle
            if (match || capture) begin
                flag_q <= 1'b1;
            end
            if (!flag_q) begin
                cpu_pass_q <= 1'b0;
            end
            // Enable is already low when the end-of-transfer request reaches the CPU; a per_transfer_irq_select request keeps it high
            channel0_compare_a_irq <= flag_q & compare_a_irq_enable
                                      & (~source_activation_enable | cpu_pass_q);
        end
    end

endmodule // ttb_block_xfer
`default_nettype wire

// *** verification/ttb_block_xfer_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module ttb_block_xfer_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        xfer_req,
    input wire logic        xfer_we,
    input wire logic [23:0] xfer_addr,
    input wire logic [31:0] xfer_wdata,
    input wire logic [31:0] xfer_rdata,
    input wire logic        xfer_ack,
    input wire logic        channel0_compare_a_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd_ack; xfer_req && !xfer_we && xfer_ack; endsequence
    sequence s_wr_ack; xfer_req && xfer_we && xfer_ack; endsequence
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_rdy1; pready |=> !pready; endproperty
    a_rdy1: assert property (p_rdy1) else $error("ready too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_errz; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_errz: assert property (p_errz) else $error("refused read data");
    property p_hold; xfer_req && !xfer_ack |=> xfer_req && $stable(xfer_addr) && $stable(xfer_we);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_rw; s_rd_ack |=> xfer_req && xfer_we && xfer_wdata == $past(xfer_rdata);
    endproperty
    a_rw: assert property (p_rw) else $error("write after read");
    property p_wend; s_wr_ack |=> !xfer_req; endproperty
    a_wend: assert property (p_wend) else $error("no gap after unit");
    property p_irq; $rose(channel0_compare_a_irq) |-> !xfer_req ##1 !xfer_req; endproperty
    a_irq: assert property (p_irq) else $error("irq during transfer");
endmodule // ttb_block_xfer_sva
bind ttb_block_xfer ttb_block_xfer_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .xfer_req, .xfer_we, .xfer_addr, .xfer_wdata, .xfer_rdata,
    .xfer_ack, .channel0_compare_a_irq);
`default_nettype wire

// *** verification/ttb_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ttb_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        xfer_req,
    input  wire logic [23:0] xfer_addr,
    output var  logic        xfer_ack,
    output wire logic [31:0] xfer_rdata
);
    logic [1:0] wait_q;
    logic       slow_q;
    // Idle bus shows a changing pattern
    assign xfer_rdata = xfer_ack ? {8'ha5, xfer_addr} : {8'h5a, ~xfer_addr};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_ack <= 1'b0;
            wait_q   <= 2'h0;
            slow_q   <= 1'b0;
        end else if (xfer_req && !xfer_ack && wait_q == 2'h0) begin
            xfer_ack <= 1'b1;
            slow_q   <= ~slow_q;
            wait_q   <= slow_q ? 2'h0 : 2'h3;
        end else begin
            xfer_ack <= 1'b0;
            if (xfer_req && !xfer_ack) wait_q <= wait_q - 2'h1;
        end
    end
endmodule // ttb_mem_model
`default_nettype wire

// *** verification/timer_triggered_block_transfer_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ttb_regs.vh"
module timer_triggered_block_transfer_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        xfer_req, xfer_we, xfer_ack, irq, pin_out, pin_oe, pin_in;
    logic [25:0] paddr;
    logic [31:0] pwdata, prdata, xfer_wdata, xfer_rdata, rd;
    logic [3:0]  pstrb;
    logic [23:0] xfer_addr;
    logic [1:0]  xfer_size;
    int          err_total, num_checks;
    logic [23:0] dst_q[$];
    logic [31:0] dat_q[$];
    logic [23:0] ci[14] = '{`TTB_IDX_MODE_A, `TTB_IDX_MODE_B, `TTB_IDX_SRC, `TTB_IDX_DEST,
        `TTB_IDX_BLK_PAIR, `TTB_IDX_TOTAL, `TTB_IDX_CMP_A, `TTB_IDX_TMODE, `TTB_IDX_CLK_CLR,
        `TTB_IDX_PIN_FN, `TTB_IDX_SYNC, `TTB_IDX_ACT_EN_B, `TTB_IDX_IRQ_EN, `TTB_IDX_RUN};
    logic [31:0] cd[14] = '{32'h88, 32'h08, 32'h200, 32'h100, 32'h202, 32'h4, 32'h9, 32'h0,
        32'h20, 32'h0, 32'h0, 32'h2000, 32'h1, 32'h1};
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ttb_block_xfer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xfer_req(xfer_req), .xfer_we(xfer_we),
        .xfer_addr(xfer_addr), .xfer_size(xfer_size), .xfer_wdata(xfer_wdata),
        .xfer_rdata(xfer_rdata), .xfer_ack(xfer_ack), .compare_a_pin_in(pin_in),
        .compare_a_pin_out(pin_out), .compare_a_pin_oe(pin_oe), .channel0_compare_a_irq(irq));
    ttb_mem_model i_mem (.pclk(pclk), .presetn(presetn), .xfer_req(xfer_req),
        .xfer_addr(xfer_addr), .xfer_ack(xfer_ack), .xfer_rdata(xfer_rdata));
    always @(posedge pclk) begin
        if (xfer_req && xfer_we && xfer_ack) begin
            dst_q.push_back(xfer_addr);
            dat_q.push_back(xfer_wdata);
        end
    end
    task automatic give_verdict(input logic timed_out);
        if (timed_out) err_total++;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [23:0] idx, input logic [31:0] wd,
                       input logic [3:0] st);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= wd;
        pstrb  <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) give_verdict(1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [23:0] idx, input logic [31:0] d, input logic [3:0] st,
                      input logic e);
        apb(1'b1, idx, d, st);
        chk("slverr", {31'h0, e}, {31'h0, er});
    endtask
    task automatic rc(input logic [23:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, 4'h0);
        chk($sformatf("reg %h", idx), exp, rd);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, pin_in} <= '0;
        err_total = 0;
        num_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rc(`TTB_IDX_COUNT, 32'h0);
        wr(`TTB_IDX_COUNT, 32'h1234, 4'h1, 1'b1);
        wr(`TTB_IDX_CMP_A, 32'h1234, 4'h2, 1'b1);
        rc(`TTB_IDX_CMP_A, 32'hffff);
        rc(24'hff6000, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        // Enable written while the source irq is still masked
        for (int i = 0; i < 14; i++) wr(ci[i], cd[i], 4'hf, 1'b0);
        apb(1'b0, `TTB_IDX_FLAGS, 32'h0, 4'h0);
        chk("dir flag", 32'h1, {31'h0, rd[7]});
        chk("pin oe", 32'h0, {31'h0, pin_oe});
        chk("pin out", 32'h0, {31'h0, pin_out});
        for (int n = 0; irq !== 1'b1; n++) begin
            if (n > 3000) give_verdict(1'b1);
            @(posedge pclk);
        end
        repeat (40) @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        rc(`TTB_IDX_ACT_EN_B, 32'h0);
        rc(`TTB_IDX_TOTAL, 32'h0);
        rc(`TTB_IDX_BLK_PAIR, 32'h202);
        chk("units", 32'h4, dst_q.size());
        chk("size", 32'h0, {30'h0, xfer_size});
        for (int i = 0; i < 4; i++) begin
            chk("dst", 32'h100 + i % 2, {8'h0, dst_q[i]});
            chk("data", 32'ha5000200 + i, dat_q[i]);
        end
        wr(`TTB_IDX_RUN, 32'h0, 4'hf, 1'b0);
        wr(`TTB_IDX_COUNT, 32'h55, 4'hf, 1'b0);
        repeat (20) @(posedge pclk);
        rc(`TTB_IDX_COUNT, 32'h55);
        wr(`TTB_IDX_FLAGS, 32'h0, 4'hf, 1'b0);
        rc(`TTB_IDX_FLAGS, 32'h80);
        // Capture on a rising pin edge while the counter is stopped
        wr(`TTB_IDX_PIN_FN, 32'h8, 4'hf, 1'b0);
        pin_in <= 1'b1;
        repeat (4) @(posedge pclk);
        rc(`TTB_IDX_CMP_A, 32'h55);
        rc(`TTB_IDX_COUNT, 32'h0);
        rc(`TTB_IDX_FLAGS, 32'h81);
        wr(`TTB_IDX_FLAGS, 32'h0, 4'hf, 1'b0);
        wr(`TTB_IDX_IRQ_EN, 32'h0, 4'hf, 1'b0);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        give_verdict(1'b0);
    end
endmodule // timer_triggered_block_transfer_tb_top
`default_nettype wire
